// [design/wsru_cfg.svh]
// Offsets, field positions, encodings and codes of the word store unit
`ifndef WSRU_CFG_SVH
`define WSRU_CFG_SVH
// Register offsets, byte addresses of aligned words
`define WSRU_OFS_CTRL  8'h00
`define WSRU_OFS_INSN  8'h04
`define WSRU_OFS_SRC   8'h08
`define WSRU_OFS_BASE  8'h0C
`define WSRU_OFS_INDEX 8'h10
`define WSRU_OFS_STAT  8'h14
`define WSRU_OFS_EA    8'h18
`define WSRU_OFS_BOUT  8'h1C
// Control register bit positions
`define WSRU_CTRL_GO    0
`define WSRU_CTRL_SO    1
`define WSRU_CTRL_FLSTA 2
// Opcode and extended opcode encodings
`define WSRU_OP_X      6'h1F
`define WSRU_OP_STW    6'h24
`define WSRU_OP_STWU   6'h25
`define WSRU_XO_LWARX  10'h014
`define WSRU_XO_STWCX  10'h096
`define WSRU_XO_STWX   10'h097
`define WSRU_XO_STWUX  10'h0B7
// Field values
`define WSRU_RA_NONE   5'h00
`define WSRU_WORD_LSB  2'h0
`define WSRU_CR0_CLR   2'h0
`define WSRU_D_W       16
// Bus answers and reset values
`define WSRU_RESP_OKAY   2'h0
`define WSRU_RESP_SLVERR 2'h2
`define WSRU_WORD_RST    32'h0000_0000
`define WSRU_CR0_RST     4'h0
`endif

// [design/wsru_ea.sv]
// Effective address adder for indexed and displacement word stores
`timescale 1ns/100ps
`include "wsru_cfg.svh"
module wsru_ea
  import wsru_pkg::*;
(
  // Instruction and operand values
  input  wire logic [31:0] insn,
  input  wire logic [31:0] base_val,
  input  wire logic [31:0] index_val,
  // Result
  output logic      [31:0] effective_address
);
  logic        base_zero;   // Base field selects zero
  logic [31:0] base_term;   // Base operand or zero
  logic [31:0] disp_ext;    // Sign-extended displacement
  logic        dform;       // Displacement form
  logic [31:0] offs_term;   // Index or displacement

  // Base field of zero means a literal zero, not register zero
  assign base_zero = insn[20:16] == `WSRU_RA_NONE;
  assign base_term = base_zero ? '0 : base_val;
  // Displacement sign bit copied into the upper half
  assign disp_ext  = {{(32-`WSRU_D_W){insn[15]}}, insn[15:0]};
  assign dform     = insn[31:26] != `WSRU_OP_X;
  assign offs_term = dform ? disp_ext : index_val;
  // Carry out of bit 31 is dropped, addresses wrap
  assign effective_address = base_term + offs_term;
endmodule

// [design/wsru_pkg.sv]
// Types shared by the word store unit
package wsru_pkg;
  // Sequencer states
  typedef enum {WS_IDLE, WS_EXEC} wsru_state_t;
  // Store request toward the data storage path
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } wsru_st_req_t;
  // Conditions reported by the storage path for the current access
  typedef struct packed {
    logic dtlb_miss;
    logic dstor;
    logic dac_hit;
    logic data_value_compare;
  } wsru_fault_t;
  // Interrupts decided for the executed instruction
  typedef struct packed {
    logic invalid;
    logic dtlb;
    logic align;
    logic dstor;
    logic debug;
  } wsru_exc_t;
  // Status word layout, high bits first from the left
  typedef struct packed {
    wsru_exc_t  exc;
    logic       stored;
    logic       wb;
    logic       busy;
    logic       resv;
    logic [3:0] cond_field0;
  } wsru_status_t;
endpackage

// [design/wsru_top.sv]
// Word store and conditional store executor with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "wsru_cfg.svh"
module wsru_top
  import wsru_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Data storage path
  input  wsru_pkg::wsru_fault_t  faults,
  output wsru_pkg::wsru_st_req_t st_req
);
  import wsru_pkg::*;

  // Reset synchroniser, release only
  logic rs_q1_r;
  logic rs_q2_r;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs_q1_r <= 1'b0;
      rs_q2_r <= 1'b0;
    end
    else
    begin
      rs_q1_r <= 1'b1;
      rs_q2_r <= rs_q1_r;
    end
  end
  assign rst_sync_n = rs_q2_r;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] wsru_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[8*i +: 8] = new_w[8*i +: 8];
    end
    return res;
  endfunction

  // Match of an extended-opcode instruction
  function automatic logic wsru_xop(
    input logic [31:0] i,
    input logic [9:0]  xo);
    return (i[31:26] == `WSRU_OP_X) && (i[10:1] == xo);
  endfunction

  // Bus side state
  logic              awready_r;   // Address slot free
  logic              wready_r;    // Data slot free
  logic              aw_hold_r;   // Address waiting
  logic              w_hold_r;    // Data waiting
  logic [ADDR_W-1:0] aw_addr_r;   // Held write address
  logic [31:0]       w_data_r;    // Held write data
  logic [3:0]        w_strb_r;    // Held byte enables
  logic              bvalid_r;    // Write answer pending
  logic [1:0]        bresp_r;     // Write answer code
  logic              arready_r;   // Read slot free
  logic              rvalid_r;    // Read answer pending
  logic [31:0]       rdata_r;     // Read answer data
  logic [1:0]        rresp_r;     // Read answer code

  // Software visible operand and control registers
  logic [31:0]  insn_r;           // Instruction word
  logic [31:0]  src_r;            // Source register value
  logic [31:0]  base_r;           // Base register value
  logic [31:0]  index_r;          // Index register value
  logic         so_r;             // Summary overflow copy
  logic         force_r;          // Force alignment setting

  // Execution results
  wsru_state_t  state_r;
  wsru_state_t  state_nxt;
  logic         resv_r;           // Reservation bit
  logic         resv_nxt;
  logic [3:0]   cr0_r;            // Condition field 0
  logic [3:0]   cr0_nxt;
  wsru_exc_t    exc_r;            // Last interrupt decision
  logic [31:0]  ea_r;             // Last effective address
  logic [31:0]  bout_r;           // Updated base value
  logic         wb_r;             // Base was updated
  logic         stored_r;         // Storage write made
  wsru_st_req_t st_r;             // Store request out

  // Write channel handshakes
  logic aw_hs;
  logic w_hs;
  logic wr_do;
  logic aw_hold_nxt;
  logic w_hold_nxt;
  assign aw_hs       = s_axi_awvalid & awready_r;
  assign w_hs        = s_axi_wvalid & wready_r;
  // Both halves in hand and no answer outstanding
  assign wr_do       = aw_hold_r & w_hold_r & ~bvalid_r;
  assign aw_hold_nxt = (aw_hold_r | aw_hs) & ~wr_do;
  assign w_hold_nxt  = (w_hold_r | w_hs) & ~wr_do;

  // Write address decode
  logic wr_ctrl;
  logic wr_insn;
  logic wr_src;
  logic wr_base;
  logic wr_index;
  logic wr_hit;
  assign wr_ctrl  = wr_do & (aw_addr_r == `WSRU_OFS_CTRL);
  assign wr_insn  = wr_do & (aw_addr_r == `WSRU_OFS_INSN);
  assign wr_src   = wr_do & (aw_addr_r == `WSRU_OFS_SRC);
  assign wr_base  = wr_do & (aw_addr_r == `WSRU_OFS_BASE);
  assign wr_index = wr_do & (aw_addr_r == `WSRU_OFS_INDEX);
  // Read-only and unmapped words answer with an error
  assign wr_hit   = wr_ctrl | wr_insn | wr_src | wr_base | wr_index;

  // Control word as stored and as written
  logic [31:0] ctrl_rd;
  logic [31:0] ctrl_new;
  logic        go_w;
  assign ctrl_rd  = (32'(so_r) << `WSRU_CTRL_SO)
                  | (32'(force_r) << `WSRU_CTRL_FLSTA);
  assign ctrl_new = wsru_merge(ctrl_rd, w_data_r, w_strb_r);
  // A start while busy is dropped; execution takes one cycle
  assign go_w     = wr_ctrl & ctrl_new[`WSRU_CTRL_GO]
                  & (state_r == WS_IDLE);

  // Bus channel flops
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `WSRU_RESP_OKAY;
    end
    else
    begin
      awready_r <= ~aw_hold_nxt;
      wready_r  <= ~w_hold_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      bvalid_r  <= wr_do | (bvalid_r & ~s_axi_bready);
      if (wr_do)
        bresp_r <= wr_hit ? `WSRU_RESP_OKAY : `WSRU_RESP_SLVERR;
    end
  end

  // Held write payload, no reset needed for function
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_addr_r <= '0;
      w_data_r  <= `WSRU_WORD_RST;
      w_strb_r  <= '0;
    end
    else
    begin
      if (aw_hs)
        aw_addr_r <= s_axi_awaddr;
      if (w_hs)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // Operand and control registers
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      insn_r  <= `WSRU_WORD_RST;
      src_r   <= `WSRU_WORD_RST;
      base_r  <= `WSRU_WORD_RST;
      index_r <= `WSRU_WORD_RST;
      so_r    <= 1'b0;
      force_r <= 1'b0;
    end
    else
    begin
      if (wr_insn)
        insn_r <= wsru_merge(insn_r, w_data_r, w_strb_r);
      if (wr_src)
        src_r <= wsru_merge(src_r, w_data_r, w_strb_r);
      if (wr_base)
        base_r <= wsru_merge(base_r, w_data_r, w_strb_r);
      if (wr_index)
        index_r <= wsru_merge(index_r, w_data_r, w_strb_r);
      if (wr_ctrl)
      begin
        so_r    <= ctrl_new[`WSRU_CTRL_SO];
        force_r <= ctrl_new[`WSRU_CTRL_FLSTA];
      end
    end
  end

  // Address generation
  logic [31:0] ea_w;
  wsru_ea u_ea (
    .insn              (insn_r),
    .base_val          (base_r),
    .index_val         (index_r),
    .effective_address (ea_w)
  );

  // Instruction decode
  logic exec_w;
  logic ra_zero;
  logic is_cx;
  logic is_x;
  logic is_ux;
  logic is_u;
  logic is_d;
  logic is_lr;
  logic is_upd;
  logic is_st;
  assign exec_w  = state_r == WS_EXEC;
  assign ra_zero = insn_r[20:16] == `WSRU_RA_NONE;
  // Conditional store only exists with the record bit set
  assign is_cx   = wsru_xop(insn_r, `WSRU_XO_STWCX) & insn_r[0];
  assign is_x    = wsru_xop(insn_r, `WSRU_XO_STWX);
  assign is_ux   = wsru_xop(insn_r, `WSRU_XO_STWUX);
  assign is_u    = insn_r[31:26] == `WSRU_OP_STWU;
  assign is_d    = insn_r[31:26] == `WSRU_OP_STW;
  assign is_lr   = wsru_xop(insn_r, `WSRU_XO_LWARX);
  assign is_upd  = is_u | is_ux;
  assign is_st   = is_cx | is_x | is_ux | is_u | is_d;

  // Interrupt decision; misaligned accesses trap only with force alignment set
  logic      misal;
  logic      chk_gate;
  logic      mem_op;
  logic      ok;
  logic      do_store;
  wsru_exc_t exc_w;
  assign misal    = ea_w[1:0] != `WSRU_WORD_LSB;
  assign mem_op   = is_st | is_lr;
  // Unreserved conditional store suppresses only the storage and debug checks
  assign chk_gate = ~is_cx | resv_r;
  assign exc_w.invalid = ~mem_op | (is_upd & ra_zero);
  assign exc_w.dtlb    = mem_op & faults.dtlb_miss;
  assign exc_w.align   = mem_op & force_r & misal;
  assign exc_w.dstor   = mem_op & chk_gate & faults.dstor;
  assign exc_w.debug   = mem_op & chk_gate
                       & (faults.dac_hit | faults.data_value_compare);
  assign ok       = ~(|exc_w);
  // Failing conditional store makes no access at all
  assign do_store = ok & is_st & (~is_cx | resv_r);

  // Reservation and condition field next values
  assign resv_nxt = (exec_w & ok & is_lr) ? 1'b1
                  : (exec_w & ok & is_cx) ? 1'b0
                  : resv_r;
  // Indexed plain stores leave the field untouched
  assign cr0_nxt  = (exec_w & ok & is_cx)
                  ? {`WSRU_CR0_CLR, resv_r, so_r}
                  : cr0_r;

  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      WS_IDLE: if (go_w) state_nxt = WS_EXEC;
      WS_EXEC: state_nxt = WS_IDLE;
    endcase
  end

  // Execution result flops; reset leaves no reservation
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_r <= WS_IDLE;
      resv_r  <= 1'b0;
      cr0_r   <= `WSRU_CR0_RST;
    end
    else
    begin
      state_r <= state_nxt;
      resv_r  <= resv_nxt;
      cr0_r   <= cr0_nxt;
    end
  end

  // Store request and record of the last instruction
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st_r     <= '0;
      exc_r    <= '0;
      ea_r     <= `WSRU_WORD_RST;
      bout_r   <= `WSRU_WORD_RST;
      wb_r     <= 1'b0;
      stored_r <= 1'b0;
    end
    else
    begin
      st_r.valid <= exec_w & do_store;
      if (exec_w)
      begin
        st_r.addr <= ea_w;
        st_r.data <= src_r;
        exc_r     <= exc_w;
        ea_r      <= ea_w;
        stored_r  <= do_store;
        // Only update forms write the base back
        wb_r      <= ok & is_upd;
      end
      if (exec_w & ok & is_upd)
        bout_r <= ea_w;
    end
  end

  // Read decode
  wsru_status_t stat_w;
  logic [31:0]  rd_val;
  logic         rd_hit;
  logic         ar_hs;
  assign stat_w = '{exc: exc_r, stored: stored_r, wb: wb_r,
                    busy: exec_w, resv: resv_r,
                    cond_field0: cr0_r};
  assign ar_hs  = s_axi_arvalid & arready_r;
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `WSRU_OFS_CTRL:  rd_val = ctrl_rd;
      `WSRU_OFS_INSN:  rd_val = insn_r;
      `WSRU_OFS_SRC:   rd_val = src_r;
      `WSRU_OFS_BASE:  rd_val = base_r;
      `WSRU_OFS_INDEX: rd_val = index_r;
      `WSRU_OFS_STAT:  rd_val = 32'(stat_w);
      `WSRU_OFS_EA:    rd_val = ea_r;
      `WSRU_OFS_BOUT:  rd_val = bout_r;
      default:
      begin
        rd_val = `WSRU_WORD_RST;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel flops
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= `WSRU_WORD_RST;
      rresp_r   <= `WSRU_RESP_OKAY;
    end
    else
    begin
      rvalid_r  <= ar_hs | (rvalid_r & ~s_axi_rready);
      arready_r <= ~(ar_hs | (rvalid_r & ~s_axi_rready));
      if (ar_hs)
      begin
        rdata_r <= rd_val;
        rresp_r <= rd_hit ? `WSRU_RESP_OKAY : `WSRU_RESP_SLVERR;
      end
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign st_req        = st_r;

  // Checks on execution
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  property p_ea_index;
    exec_w && (is_x || is_cx || is_ux) |->
      ea_w == 32'((ra_zero ? '0 : base_r) + index_r);
  endproperty
  a_ea_index: assert property (p_ea_index)
    else $error("indexed address wrong");

  property p_cx_write;
    exec_w && is_cx && ok && resv_r |=>
      st_r.valid && st_r.data == $past(src_r) && !resv_r;
  endproperty
  a_cx_write: assert property (p_cx_write)
    else $error("reserved conditional store not done");

  property p_cx_nowrite;
    exec_w && is_cx && !resv_r |=> !st_r.valid ##1 !st_r.valid;
  endproperty
  a_cx_nowrite: assert property (p_cx_nowrite)
    else $error("unreserved conditional store wrote");

  property p_cr0;
    exec_w && is_cx && ok |=>
      cr0_r == {`WSRU_CR0_CLR, $past(resv_r), $past(so_r)};
  endproperty
  a_cr0: assert property (p_cr0)
    else $error("condition field wrong after conditional store");

  property p_resv_clear;
    exec_w && is_cx && ok |=> !resv_r;
  endproperty
  a_resv_clear: assert property (p_resv_clear)
    else $error("reservation left set");

  property p_resv_set;
    $rose(resv_r) |-> $past(exec_w) && $past(is_lr);
  endproperty
  a_resv_set: assert property (p_resv_set)
    else $error("reservation set by other instruction");

  property p_no_dsi;
    exec_w && is_cx && !resv_r |=> !exc_r.dstor && !exc_r.debug;
  endproperty
  a_no_dsi: assert property (p_no_dsi)
    else $error("storage or debug trap on failed store");

  property p_dtlb;
    exec_w && is_cx && faults.dtlb_miss |=> exc_r.dtlb && !st_r.valid;
  endproperty
  a_dtlb: assert property (p_dtlb)
    else $error("TLB miss not raised");

  property p_align;
    exec_w && is_cx && force_r && misal |=> exc_r.align;
  endproperty
  a_align: assert property (p_align)
    else $error("alignment trap missing");

  property p_upd_base;
    exec_w && is_upd && ok |=> wb_r && bout_r == st_r.addr;
  endproperty
  a_upd_base: assert property (p_upd_base)
    else $error("base not updated with address");

  property p_upd_zero;
    exec_w && is_upd && ra_zero |=> exc_r.invalid && !st_r.valid;
  endproperty
  a_upd_zero: assert property (p_upd_zero)
    else $error("zero base update form accepted");

  property p_plain_x;
    exec_w && is_x |=> !wb_r && $stable(cr0_r);
  endproperty
  a_plain_x: assert property (p_plain_x)
    else $error("plain indexed store changed a register");
endmodule

// [testbench/word_store_reservation_unit_tb.sv]
// Bench for the word store unit through its register bus
`timescale 1ns/100ps
`include "wsru_cfg.svh"
module word_store_reservation_unit_tb;
  import wsru_pkg::*;
  // Bus and clock
  logic        clk, rst_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // Storage path and results
  wsru_fault_t  faults, fault_cmd;
  wsru_st_req_t st_req;
  logic [31:0]  last_addr, last_data, rd, stat;
  logic [7:0]   wr_cnt;
  int           error_cnt, cmp_count, cyc, r;
  // Operand values
  localparam logic [31:0] SRC = 32'hCAFE_0123;
  localparam logic [31:0] BASE = 32'h0000_1000;
  localparam logic [31:0] IDX = 32'h0000_0020;

  wsru_top #(.ADDR_W(8)) uut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .faults, .st_req);
  wsru_store_model mem (.clk, .st_req, .fault_cmd, .faults, .last_addr,
    .last_data, .wr_cnt);

  always #50 clk = ~clk;

  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  // Read: rready held until rvalid is sampled
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                        input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Load instruction and mode bits, start, then fetch the status word
  task automatic run(input logic [31:0] insn, input logic [1:0] ctl);
    wr(`WSRU_OFS_INSN, insn, `WSRU_RESP_OKAY);
    wr(`WSRU_OFS_CTRL, {29'h0, ctl, 1'b0}, `WSRU_RESP_OKAY);
    wr(`WSRU_OFS_CTRL, {29'h0, ctl, 1'b1}, `WSRU_RESP_OKAY);
    repeat (3) @(posedge clk);
    rd_reg(`WSRU_OFS_STAT, stat, `WSRU_RESP_OKAY);
  endtask

  // X-form word with source 3 and index 4, record bit 0 set last
  function automatic logic [31:0] ix(input logic [9:0] xo,
                                     input logic [4:0] ra);
    return {`WSRU_OP_X, 5'h03, ra, 5'h04, xo, 1'b1};
  endfunction

  // Expected status: interrupts, stored, write-back, reservation, cond
  function automatic logic [31:0] sx(input logic [4:0] e, input logic s,
                                     input logic w, input logic v,
                                     input logic [3:0] c);
    return {19'h0, e, s, w, 1'b0, v, c};
  endfunction

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    fault_cmd = '0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (r = 0; r < 8; r++)
    begin
      rd_reg(8'(4 * r), rd, `WSRU_RESP_OKAY);
      chk(rd, 32'h0);
    end
    rd_reg(8'h20, rd, `WSRU_RESP_SLVERR);
    chk(rd, 32'h0);
    wr(`WSRU_OFS_STAT, 32'hFFFF_FFFF, `WSRU_RESP_SLVERR);
    wr(8'h20, 32'h1, `WSRU_RESP_SLVERR);
    wr(`WSRU_OFS_SRC, SRC, `WSRU_RESP_OKAY);
    wr(`WSRU_OFS_BASE, BASE, `WSRU_RESP_OKAY);
    wr(`WSRU_OFS_INDEX, IDX, `WSRU_RESP_OKAY);
    // Unreserved store with storage and debug hits pending
    fault_cmd <= 4'b0111;
    run(ix(`WSRU_XO_STWCX, 5'h01), 2'b01);
    chk(stat, sx(5'h00, 1'b0, 1'b0, 1'b0, 4'h1));
    chk(32'(wr_cnt), 32'h0);
    fault_cmd <= '0;
    run(ix(`WSRU_XO_LWARX, 5'h01), 2'b00);
    chk(stat, sx(5'h00, 1'b0, 1'b0, 1'b1, 4'h1));
    // Successful store with summary overflow set copies it to bit 0
    run(ix(`WSRU_XO_STWCX, 5'h01), 2'b01);
    chk(stat, sx(5'h00, 1'b1, 1'b0, 1'b0, 4'h3));
    chk(last_addr, BASE + IDX);
    chk(last_data, SRC);
    // Zero base field uses zero, not the base value
    run(ix(`WSRU_XO_LWARX, 5'h01), 2'b00);
    run(ix(`WSRU_XO_STWCX, `WSRU_RA_NONE), 2'b00);
    chk(last_addr, IDX);
    rd_reg(`WSRU_OFS_EA, rd, `WSRU_RESP_OKAY);
    chk(rd, IDX);
    run(ix(`WSRU_XO_STWX, 5'h01), 2'b00);
    chk(stat, sx(5'h00, 1'b1, 1'b0, 1'b0, 4'h2));
    chk(last_addr, BASE + IDX);
    // Negative displacement with update
    run({`WSRU_OP_STWU, 5'h03, 5'h01, 16'hFFF0}, 2'b00);
    chk(stat, sx(5'h00, 1'b1, 1'b1, 1'b0, 4'h2));
    chk(last_addr, BASE - 32'h10);
    rd_reg(`WSRU_OFS_BOUT, rd, `WSRU_RESP_OKAY);
    chk(rd, BASE - 32'h10);
    run(ix(`WSRU_XO_STWUX, 5'h01), 2'b00);
    rd_reg(`WSRU_OFS_BOUT, rd, `WSRU_RESP_OKAY);
    chk(rd, BASE + IDX);
    chk(last_data, SRC);
    run({`WSRU_OP_STWU, 5'h03, `WSRU_RA_NONE, 16'h0004}, 2'b00);
    chk(stat, sx(5'h10, 1'b0, 1'b0, 1'b0, 4'h2));
    // TLB miss with reservation off, then on
    for (r = 0; r < 2; r++)
    begin
      // Fault line is cleared only around the reserve-load, never twice
      // in one step
      if (r == 1)
      begin
        fault_cmd <= '0;
        run(ix(`WSRU_XO_LWARX, 5'h01), 2'b00);
      end
      fault_cmd <= 4'b1000;
      run(ix(`WSRU_XO_STWCX, 5'h01), 2'b00);
      chk(stat, sx(5'h08, 1'b0, 1'b0, r[0], 4'h2));
    end
    fault_cmd <= '0;
    wr(`WSRU_OFS_INDEX, 32'h0000_0022, `WSRU_RESP_OKAY);
    run(ix(`WSRU_XO_STWCX, 5'h01), 2'b10);
    chk(stat, sx(5'h04, 1'b0, 1'b0, 1'b1, 4'h2));
    // Misaligned without forcing still executes
    run(ix(`WSRU_XO_STWCX, 5'h01), 2'b00);
    chk(stat, sx(5'h00, 1'b1, 1'b0, 1'b0, 4'h2));
    chk(last_addr, BASE + 32'h22);
    chk(32'(wr_cnt), 32'h6);
    complete_run();
  end
endmodule

// [testbench/wsru_store_model.sv]
// Storage path model: reports commanded faults, records store pulses
`timescale 1ns/100ps
module wsru_store_model
  import wsru_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Store side of the unit
  input  wsru_pkg::wsru_st_req_t st_req,
  input  wsru_pkg::wsru_fault_t  fault_cmd,
  output wsru_pkg::wsru_fault_t  faults,
  // Record of accepted writes
  output logic [31:0]            last_addr,
  output logic [31:0]            last_data,
  output logic [7:0]             wr_cnt
);
  // Faults only as the bench commands, never invented here
  assign faults = fault_cmd;
  initial
  begin
    last_addr = 32'h0000_0000;
    last_data = 32'h0000_0000;
    wr_cnt = 8'h00;
  end
  // No ready line: every pulse is taken as one whole word
  always @(posedge clk)
  begin
    if (st_req.valid === 1'b1)
    begin
      last_addr <= st_req.addr;
      last_data <= st_req.data;
      wr_cnt <= wr_cnt + 8'h01;
    end
  end
endmodule
